// ### smc_pkg.sv
package smc_pkg;

    // ********************
    // Configuration word layout
    // ********************
    localparam int CFG_W = 16;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam int SCAN_LSB = 14;
    localparam int SCAN_W = 2;
    localparam int CAL_BIT = 13;
    localparam int CHAN_LSB = 8;
    localparam int CHAN_W = 2;
    localparam int ROUTE_LSB = 0;
    localparam int ROUTE_W = 6;
    localparam logic [4:0] FULL_COUNT = 5'h10;

    // ********************
    // Routing codes held in the low six bits
    // ********************
    localparam logic [5:0] ROUTE_NONE = 6'h00;
    localparam logic [5:0] ROUTE_TEMP_MUX = 6'h20;
    localparam logic [5:0] ROUTE_BUS_IN = 6'h23;
    localparam logic [5:0] ROUTE_DRV_CHAN = 6'h02;
    localparam logic [5:0] ROUTE_DRV_TEMP = 6'h22;

    typedef enum logic [6:0] {
        SMC_PARALLEL = 7'h01,
        SMC_MUX_CHAN = 7'h02,
        SMC_MUX_TEMP = 7'h04,
        SMC_BUS_IN = 7'h08,
        SMC_DRV_CHAN = 7'h10,
        SMC_DRV_TEMP = 7'h20,
        SMC_RESERVED = 7'h40
    } smc_mode_t;

    // ********************
    // Pin sampling
    // ********************
    localparam int PIN_W = 5;
    localparam int PIN_SCLK = 0;
    localparam int PIN_DIN = 1;
    localparam int PIN_DSEL = 2;
    localparam int PIN_SEL_N = 3;
    localparam int PIN_BP_N = 4;
    localparam logic [4:0] PIN_IDLE = 5'h1D;
    localparam logic SERIAL_OUT_IDLE = 1'h0;

    // ********************
    // Register map
    // ********************
    localparam int AXI_AW = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LOADS = 4'h8;
    localparam int CTRL_LINK_EN_BIT = 0;
    localparam int CTRL_SOFT_CLR_BIT = 1;
    localparam logic CTRL_LINK_EN_RESET = 1'h1;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_CHAN_LSB = 8;
    localparam int ST_CAL_BIT = 10;
    localparam int ST_DRIVE_BIT = 11;
    localparam int ST_BUS_IN_BIT = 12;
    localparam int ST_TEMP_BIT = 13;
    localparam int ST_PARALLEL_BIT = 14;
    localparam int ST_BUSY_BIT = 16;
    localparam int ST_LINK_EN_BIT = 17;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : smc_pkg

// ### smc_route_decode.sv
`timescale 1ns/100ps
module smc_route_decode (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] cfg,
    output smc_pkg::smc_mode_t mode,
    output logic [1:0] mux_channel,
    output logic shunt_cal_enable,
    output logic bus_drive_enable,
    output logic bus_to_first_mux,
    output logic temp_to_mux,
    output logic parallel_outputs
);

    // ********************
    // Pattern decode
    // ********************
    // Bits 12..10 and 7..6 are never looked at, so they cannot change the routing.
    logic [1:0] scan_bits;
    logic cal_bit;
    logic [1:0] chan_bits;
    logic [5:0] route_bits;
    smc_pkg::smc_mode_t next_mode;

    assign scan_bits = cfg[smc_pkg::SCAN_LSB +: smc_pkg::SCAN_W];
    assign cal_bit = cfg[smc_pkg::CAL_BIT];
    assign chan_bits = cfg[smc_pkg::CHAN_LSB +: smc_pkg::CHAN_W];
    assign route_bits = cfg[smc_pkg::ROUTE_LSB +: smc_pkg::ROUTE_W];

    always_comb
    begin
        next_mode = smc_pkg::SMC_RESERVED;
        if (scan_bits == 2'h0)
        begin
            if (route_bits == smc_pkg::ROUTE_NONE)
            begin
                if (!cal_bit && chan_bits == 2'h0)
                begin
                    next_mode = smc_pkg::SMC_PARALLEL;
                end
                else
                begin
                    next_mode = smc_pkg::SMC_MUX_CHAN;
                end
            end
            else if (route_bits == smc_pkg::ROUTE_TEMP_MUX && !cal_bit)
            begin
                next_mode = smc_pkg::SMC_MUX_TEMP;
            end
            else if (route_bits == smc_pkg::ROUTE_BUS_IN && !cal_bit)
            begin
                next_mode = smc_pkg::SMC_BUS_IN;
            end
            else if (route_bits == smc_pkg::ROUTE_DRV_CHAN)
            begin
                next_mode = smc_pkg::SMC_DRV_CHAN;
            end
            else if (route_bits == smc_pkg::ROUTE_DRV_TEMP && !cal_bit)
            begin
                next_mode = smc_pkg::SMC_DRV_TEMP;
            end
        end
    end

    // ********************
    // Registered routing controls
    // ********************
    // Unknown patterns decode to SMC_RESERVED, which sets the same routing outputs as reset, so the bus is never driven by mistake.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode <= smc_pkg::SMC_PARALLEL;
            mux_channel <= 2'h0;
            shunt_cal_enable <= 1'h0;
            bus_drive_enable <= 1'h0;
            bus_to_first_mux <= 1'h0;
            temp_to_mux <= 1'h0;
            parallel_outputs <= 1'h1;
        end
        else
        begin
            mode <= next_mode;
            mux_channel <= (next_mode == smc_pkg::SMC_MUX_CHAN || next_mode == smc_pkg::SMC_DRV_CHAN) ?
                chan_bits : 2'h0;
            shunt_cal_enable <= cal_bit &&
                (next_mode == smc_pkg::SMC_MUX_CHAN || next_mode == smc_pkg::SMC_DRV_CHAN);
            bus_drive_enable <= (next_mode == smc_pkg::SMC_DRV_CHAN || next_mode == smc_pkg::SMC_DRV_TEMP);
            bus_to_first_mux <= (next_mode == smc_pkg::SMC_BUS_IN);
            temp_to_mux <= (next_mode == smc_pkg::SMC_MUX_TEMP || next_mode == smc_pkg::SMC_DRV_TEMP);
            parallel_outputs <= (next_mode == smc_pkg::SMC_PARALLEL || next_mode == smc_pkg::SMC_RESERVED);
        end
    end

endmodule : smc_route_decode

// ### smc_config_top.sv
`timescale 1ns/100ps
module smc_config_top #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_clock_line,
    input wire logic serial_in_line,
    input wire logic data_or_slot_select,
    input wire logic module_select_n,
    input wire logic backplane_reset_n,
    output logic serial_out_line,
    output smc_pkg::smc_mode_t mode,
    output logic [1:0] channel_field,
    output logic shunt_cal_enable,
    output logic bus_drive_enable,
    output logic bus_to_first_mux,
    output logic temp_to_mux,
    output logic parallel_outputs
);

    // ********************
    // Elaboration checks
    // ********************
    if (SYNC_STAGES < 2)
    begin : g_sync_check
        $error("SYNC_STAGES must be at least two.");
    end

    // ********************
    // Helper functions
    // ********************
    function automatic logic addr_mapped(input logic [3:0] addr);
        addr_mapped = (addr == smc_pkg::REG_CTRL) || (addr == smc_pkg::REG_STATUS) ||
            (addr == smc_pkg::REG_LOADS);
    endfunction : addr_mapped

    function automatic logic rise(input logic now_level, input logic last_level);
        rise = now_level && !last_level;
    endfunction : rise

    // ********************
    // Pin synchronisers
    // ********************
    // Only the last stage of the chain is read by any logic.
    logic [SYNC_STAGES-1:0][smc_pkg::PIN_W-1:0] sync_chain, next_sync_chain;
    logic [smc_pkg::PIN_W-1:0] pins_now, pins_last;

    always_comb
    begin
        next_sync_chain[0] = {backplane_reset_n, module_select_n, data_or_slot_select,
            serial_in_line, serial_clock_line};
        for (int i = 1; i < SYNC_STAGES; i++)
        begin
            next_sync_chain[i] = sync_chain[i-1];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_chain <= {SYNC_STAGES{smc_pkg::PIN_IDLE}};
            pins_last <= smc_pkg::PIN_IDLE;
        end
        else
        begin
            sync_chain <= next_sync_chain;
            pins_last <= pins_now;
        end
    end

    assign pins_now = sync_chain[SYNC_STAGES-1];

    // ********************
    // Serial link and configuration word
    // ********************
    logic [15:0] shift_word, next_shift_word;
    logic [4:0] bit_count, next_bit_count;
    logic [15:0] cfg_word, next_cfg_word;
    logic [31:0] load_count, next_load_count;
    logic link_enable, next_link_enable;
    logic soft_clear, next_soft_clear;
    logic sclk_rise, select_active, select_release, data_phase;

    assign sclk_rise = rise(pins_now[smc_pkg::PIN_SCLK], pins_last[smc_pkg::PIN_SCLK]);
    assign select_active = !pins_now[smc_pkg::PIN_SEL_N];
    assign select_release = rise(pins_now[smc_pkg::PIN_SEL_N], pins_last[smc_pkg::PIN_SEL_N]);
    assign data_phase = !pins_now[smc_pkg::PIN_DSEL];

    always_comb
    begin
        next_shift_word = shift_word;
        next_bit_count = bit_count;
        next_cfg_word = cfg_word;
        next_load_count = load_count;
        if (select_active && data_phase && sclk_rise && link_enable)
        begin
            next_shift_word = {shift_word[14:0], pins_now[smc_pkg::PIN_DIN]};
            if (bit_count != smc_pkg::FULL_COUNT)
            begin
                next_bit_count = bit_count + 5'h01;
            end
        end
        if (select_release)
        begin
            // A short frame is dropped whole rather than loading a half-shifted word.
            if (bit_count == smc_pkg::FULL_COUNT)
            begin
                next_cfg_word = shift_word;
                next_load_count = load_count + 32'h0000_0001;
            end
            next_bit_count = 5'h00;
        end
        if (!pins_now[smc_pkg::PIN_BP_N] || soft_clear)
        begin
            next_cfg_word = smc_pkg::CFG_RESET;
            next_bit_count = 5'h00;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            shift_word <= 16'h0000;
            bit_count <= 5'h00;
            cfg_word <= smc_pkg::CFG_RESET;
            load_count <= 32'h0000_0000;
        end
        else
        begin
            shift_word <= next_shift_word;
            bit_count <= next_bit_count;
            cfg_word <= next_cfg_word;
            load_count <= next_load_count;
        end
    end

    // The readback line carries nothing; the word is write-only on the link.
    assign serial_out_line = smc_pkg::SERIAL_OUT_IDLE;

    // ********************
    // Routing decode
    // ********************
    smc_route_decode u_decode (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg_word),
        .mode(mode),
        .mux_channel(channel_field),
        .shunt_cal_enable(shunt_cal_enable),
        .bus_drive_enable(bus_drive_enable),
        .bus_to_first_mux(bus_to_first_mux),
        .temp_to_mux(temp_to_mux),
        .parallel_outputs(parallel_outputs)
    );

    // ********************
    // AXI4-Lite register slave
    // ********************
    logic aw_held, next_aw_held;
    logic [3:0] aw_addr, next_aw_addr;
    logic w_held, next_w_held;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic [31:0] status_word;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[smc_pkg::ST_MODE_LSB +: 7] = mode;
        status_word[smc_pkg::ST_CHAN_LSB +: 2] = channel_field;
        status_word[smc_pkg::ST_CAL_BIT] = shunt_cal_enable;
        status_word[smc_pkg::ST_DRIVE_BIT] = bus_drive_enable;
        status_word[smc_pkg::ST_BUS_IN_BIT] = bus_to_first_mux;
        status_word[smc_pkg::ST_TEMP_BIT] = temp_to_mux;
        status_word[smc_pkg::ST_PARALLEL_BIT] = parallel_outputs;
        status_word[smc_pkg::ST_BUSY_BIT] = select_active;
        status_word[smc_pkg::ST_LINK_EN_BIT] = link_enable;
    end

    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;

    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_link_enable = link_enable;
        next_soft_clear = 1'h0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'h1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'h1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_held && w_held && !bvalid)
        begin
            next_aw_held = 1'h0;
            next_w_held = 1'h0;
            next_bvalid = 1'h1;
            next_bresp = addr_mapped(aw_addr) ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
            if (aw_addr == smc_pkg::REG_CTRL && w_strb[0])
            begin
                next_link_enable = w_data[smc_pkg::CTRL_LINK_EN_BIT];
                next_soft_clear = w_data[smc_pkg::CTRL_SOFT_CLR_BIT];
            end
        end
        if (bvalid && s_axi_bready)
        begin
            next_bvalid = 1'h0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'h1;
            next_rresp = addr_mapped(s_axi_araddr) ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
            if (s_axi_araddr == smc_pkg::REG_CTRL)
            begin
                next_rdata = {30'h0000_0000, 1'h0, link_enable};
            end
            else if (s_axi_araddr == smc_pkg::REG_STATUS)
            begin
                next_rdata = status_word;
            end
            else if (s_axi_araddr == smc_pkg::REG_LOADS)
            begin
                next_rdata = load_count;
            end
            else
            begin
                next_rdata = 32'h0000_0000;
            end
        end
        else if (rvalid && s_axi_rready)
        begin
            next_rvalid = 1'h0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'h0;
            aw_addr <= 4'h0;
            w_held <= 1'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'h0;
            bresp <= smc_pkg::RESP_OKAY;
            rvalid <= 1'h0;
            rdata <= 32'h0000_0000;
            rresp <= smc_pkg::RESP_OKAY;
            link_enable <= smc_pkg::CTRL_LINK_EN_RESET;
            soft_clear <= 1'h0;
        end
        else
        begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            link_enable <= next_link_enable;
            soft_clear <= next_soft_clear;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

endmodule : smc_config_top

// ### smc_config_top_assertions.sv
`timescale 1ns/100ps
module smc_config_checker #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic backplane_reset_n,
    input wire logic module_select_n,
    input wire logic s_axi_wvalid,
    input wire logic serial_out_line,
    input smc_pkg::smc_mode_t mode,
    input wire logic [1:0] channel_field,
    input wire logic shunt_cal_enable,
    input wire logic bus_drive_enable,
    input wire logic bus_to_first_mux,
    input wire logic temp_to_mux,
    input wire logic parallel_outputs
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ********************
    // Routing outputs against the decoded mode
    // ********************
    a_drive_by_mode: assert property (
        bus_drive_enable == (mode == smc_pkg::SMC_DRV_CHAN || mode == smc_pkg::SMC_DRV_TEMP))
        else $error("bus driven outside a drive mode");
    a_bus_in_only: assert property (
        bus_to_first_mux |-> mode == smc_pkg::SMC_BUS_IN && !bus_drive_enable)
        else $error("bus to first output while not in bus-in mode");
    a_temp_route: assert property (
        temp_to_mux == (mode == smc_pkg::SMC_MUX_TEMP || mode == smc_pkg::SMC_DRV_TEMP))
        else $error("temperature route does not follow mode");
    a_parallel_route: assert property (
        parallel_outputs == (mode == smc_pkg::SMC_PARALLEL || mode == smc_pkg::SMC_RESERVED))
        else $error("parallel route does not follow mode");
    a_cal_channel: assert property (
        shunt_cal_enable |-> mode == smc_pkg::SMC_MUX_CHAN || mode == smc_pkg::SMC_DRV_CHAN)
        else $error("calibration outside a channel mode");
    a_chan_idle: assert property (
        !(mode == smc_pkg::SMC_MUX_CHAN || mode == smc_pkg::SMC_DRV_CHAN) |-> channel_field == 2'h0)
        else $error("channel field set outside a channel mode");
    // ********************
    // Load, clear and readback timing
    // ********************
    a_bp_clear: assert property (
        !backplane_reset_n [*5] |=> mode == smc_pkg::SMC_PARALLEL && parallel_outputs && !bus_drive_enable)
        else $error("backplane reset did not clear the routing");
    a_word_hold: assert property (
        (module_select_n && backplane_reset_n && !s_axi_wvalid) [*6] |=> $stable(mode) && $stable(channel_field))
        else $error("routing changed without a load");
    a_no_readback: assert property (
        serial_out_line == smc_pkg::SERIAL_OUT_IDLE)
        else $error("serial output carries activity");
    c_drive_chan: cover property (mode == smc_pkg::SMC_DRV_CHAN && shunt_cal_enable);
    c_bus_in: cover property (bus_to_first_mux);
    c_mux_temp: cover property (mode == smc_pkg::SMC_MUX_TEMP);
    c_bp_low: cover property (!backplane_reset_n [*5]);
endmodule : smc_config_checker

bind smc_config_top smc_config_checker #(.SYNC_STAGES(SYNC_STAGES)) u_checker (.aclk, .aresetn,
    .backplane_reset_n, .module_select_n, .s_axi_wvalid, .serial_out_line, .mode, .channel_field,
    .shunt_cal_enable, .bus_drive_enable, .bus_to_first_mux, .temp_to_mux, .parallel_outputs);

// ### smc_host_model.sv
`timescale 1ns/100ps
module smc_host_model (
    input wire logic aclk,
    output logic serial_clock_line,
    output logic serial_in_line,
    output logic data_or_slot_select,
    output logic module_select_n
);
    // ********************
    // Acquisition board side of the four-wire link
    // ********************
    initial
    begin
        serial_clock_line = 1'b1;
        serial_in_line = 1'b0;
        data_or_slot_select = 1'b1;
        module_select_n = 1'b1;
    end

    // Each clock level lasts 20 cycles, giving the 160 ns link period.
    task automatic send(input logic [15:0] w, input int nbits, input logic dsel);
        int i;
        @(posedge aclk);
        module_select_n <= 1'b0;
        data_or_slot_select <= dsel;
        repeat (20) @(posedge aclk);
        for (i = 0; i < nbits; i++)
        begin
            serial_in_line <= w[15 - i];
            serial_clock_line <= 1'b0;
            repeat (20) @(posedge aclk);
            serial_clock_line <= 1'b1;
            repeat (20) @(posedge aclk);
        end
        module_select_n <= 1'b1;
        data_or_slot_select <= 1'b1;
        // A released data line must not keep showing the last bit.
        serial_in_line <= ~serial_in_line;
        repeat (20) @(posedge aclk);
    endtask : send
endmodule : smc_host_model

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, backplane_reset_n = 1'b1;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_out_line;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic serial_clock_line, serial_in_line, data_or_slot_select, module_select_n;
    smc_pkg::smc_mode_t mode;
    logic [1:0] channel_field;
    logic shunt_cal_enable, bus_drive_enable, bus_to_first_mux, temp_to_mux, parallel_outputs;
    int num_errors = 0, num_checks = 0, loads = 0, i;
    logic [15:0] lfsr = 16'h6FD5, w;
    logic [15:0] pats [11] = '{16'h0000, 16'h0100, 16'h2300, 16'h0020, 16'h0023, 16'h0002, 16'h0202,
        16'h2102, 16'h0022, 16'h2020, 16'h4000};

    smc_config_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .serial_clock_line, .serial_in_line, .data_or_slot_select, .module_select_n,
        .backplane_reset_n, .serial_out_line, .mode, .channel_field, .shunt_cal_enable,
        .bus_drive_enable, .bus_to_first_mux, .temp_to_mux, .parallel_outputs);
    smc_host_model host (.aclk, .serial_clock_line, .serial_in_line, .data_or_slot_select, .module_select_n);

    initial
    begin
        forever #2 aclk = ~aclk;
    end

    // ********************
    // Reporting and comparison
    // ********************
    task give_verdict;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task fail(input string msg);
        num_errors++;
        $display("MISMATCH %0t %s", $time, msg);
    endtask : fail
    task check_mode(input smc_pkg::smc_mode_t got, input smc_pkg::smc_mode_t exp);
        num_checks++;
        if (got !== exp)
            fail("mode");
    endtask : check_mode
    task check_bits(input logic [6:0] got, input logic [6:0] exp);
        num_checks++;
        if (got !== exp)
            fail("routing outputs");
    endtask : check_bits
    task check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
            fail("bus value");
    endtask : check_word

    // ********************
    // Expected decode of a loaded word
    // ********************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    function automatic smc_pkg::smc_mode_t exp_mode(input logic [15:0] x);
        if (x[15:14] != 2'h0)
            return smc_pkg::SMC_RESERVED;
        case (x[5:0])
            6'h00: return (x[13] || x[9:8] != 2'h0) ? smc_pkg::SMC_MUX_CHAN : smc_pkg::SMC_PARALLEL;
            6'h02: return smc_pkg::SMC_DRV_CHAN;
            6'h20: return x[13] ? smc_pkg::SMC_RESERVED : smc_pkg::SMC_MUX_TEMP;
            6'h23: return x[13] ? smc_pkg::SMC_RESERVED : smc_pkg::SMC_BUS_IN;
            6'h22: return x[13] ? smc_pkg::SMC_RESERVED : smc_pkg::SMC_DRV_TEMP;
            default: return smc_pkg::SMC_RESERVED;
        endcase
    endfunction : exp_mode
    function automatic logic [6:0] exp_routes(input logic [15:0] x);
        smc_pkg::smc_mode_t m;
        logic ch;
        m = exp_mode(x);
        ch = (m == smc_pkg::SMC_MUX_CHAN) || (m == smc_pkg::SMC_DRV_CHAN);
        return {ch ? x[9:8] : 2'h0, ch & x[13], m == smc_pkg::SMC_DRV_CHAN || m == smc_pkg::SMC_DRV_TEMP,
            m == smc_pkg::SMC_BUS_IN, m == smc_pkg::SMC_MUX_TEMP || m == smc_pkg::SMC_DRV_TEMP,
            m == smc_pkg::SMC_PARALLEL || m == smc_pkg::SMC_RESERVED};
    endfunction : exp_routes
    function automatic logic [31:0] exp_status(input logic [15:0] x);
        logic [6:0] r;
        r = exp_routes(x);
        return {14'h0, 3'h4, r[0], r[1], r[2], r[3], r[4], r[6:5], 1'b0, exp_mode(x)};
    endfunction : exp_status

    // ********************
    // Register bus master
    // ********************
    task axi_write(input logic [3:0] a, input logic [31:0] d);
        int n;
        logic aw_open, w_open;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_open = 1'b1;
        w_open = 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (aw_open && s_axi_awready === 1'b1)
            begin
                s_axi_awvalid <= 1'b0;
                aw_open = 1'b0;
            end
            if (w_open && s_axi_wready === 1'b1)
            begin
                s_axi_wvalid <= 1'b0;
                w_open = 1'b0;
            end
            if (s_axi_bvalid === 1'b1)
                break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50)
        begin
            fail("write timeout");
            give_verdict;
        end
    endtask : axi_write
    task axi_read(input logic [3:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
                break;
        end
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50)
        begin
            fail("read timeout");
            give_verdict;
        end
    endtask : axi_read

    task check_outputs(input logic [15:0] x);
        check_mode(mode, exp_mode(x));
        check_bits({channel_field, shunt_cal_enable, bus_drive_enable, bus_to_first_mux, temp_to_mux,
            parallel_outputs}, exp_routes(x));
        axi_read(smc_pkg::REG_STATUS);
        check_word(rd, exp_status(x));
    endtask : check_outputs
    task load(input logic [15:0] x);
        host.send(x, 16, 1'b0);
        loads++;
        check_outputs(x);
    endtask : load

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        check_outputs(16'h0000);
        axi_read(smc_pkg::REG_CTRL);
        check_word(rd, 32'h0000_0001);
        axi_read(4'hC);
        check_word({rd[29:0], resp}, {30'h0, smc_pkg::RESP_SLVERR});
        axi_write(4'hC, 32'h0000_0000);
        check_word({30'h0, resp}, {30'h0, smc_pkg::RESP_SLVERR});
        axi_write(smc_pkg::REG_STATUS, 32'hFFFF_FFFF);
        check_word({30'h0, resp}, {30'h0, smc_pkg::RESP_OKAY});
        for (i = 0; i < 26; i++)
        begin
            w = (i < 22) ? (pats[i / 2] | (lfsr & 16'h1CC0)) : lfsr;
            lfsr = lfsr_next(lfsr);
            load(w);
        end
        host.send(16'h0023, 15, 1'b0);
        check_outputs(w);
        host.send(16'h0023, 16, 1'b1);
        check_outputs(w);
        load(16'h0302);
        axi_write(smc_pkg::REG_CTRL, 32'h0000_0003);
        repeat (6) @(posedge aclk);
        check_outputs(16'h0000);
        axi_write(smc_pkg::REG_CTRL, 32'h0000_0000);
        host.send(16'h0023, 16, 1'b0);
        axi_write(smc_pkg::REG_CTRL, 32'h0000_0001);
        check_outputs(16'h0000);
        load(16'h0022);
        backplane_reset_n <= 1'b0;
        repeat (10) @(posedge aclk);
        check_outputs(16'h0000);
        backplane_reset_n <= 1'b1;
        axi_read(smc_pkg::REG_LOADS);
        check_word(rd, loads);
        give_verdict;
    end
endmodule : tb_top
